// ==== core/cgpm_pkg.sv ====
package cgpm_pkg;
  localparam logic [3:0] ADDR_INDEX = 4'h8;
  localparam logic [3:0] ADDR_DATA = 4'hC;
  localparam int IDX_WE = 7;
  localparam int PIXEL_LSB = 8;
  localparam int NUM_REGS = 12;
  localparam logic [6:0] IDX_ENG_FUNC = 7'h00;
  localparam logic [6:0] IDX_ENG_BYP = 7'h01;
  localparam logic [6:0] IDX_ENG_MODE = 7'h02;
  localparam logic [6:0] IDX_ENG_SEL = 7'h03;
  localparam logic [6:0] IDX_MEM_FUNC = 7'h04;
  localparam logic [6:0] IDX_MEM_BYP = 7'h05;
  localparam logic [6:0] IDX_MEM_MODE = 7'h06;
  localparam logic [6:0] IDX_MEM_SEL = 7'h07;
  localparam logic [6:0] IDX_GEN = 7'h08;
  localparam logic [6:0] IDX_SCLK = 7'h09;
  localparam logic [6:0] IDX_MCLK = 7'h0A;
  localparam logic [6:0] IDX_DYN = 7'h0B;
  localparam logic [6:0] IDX_METER = 7'h21;
  localparam int FUNC_RESET = 0;
  localparam int FUNC_SLEEP = 1;
  localparam int FUNC_REF_LSB = 2;
  localparam int FUNC_FB_LSB = 5;
  localparam int FUNC_PULSE_EN = 13;
  localparam int FUNC_PULSE_LSB = 14;
  localparam int MEM_AS_MCLK = 26;
  localparam int FUNC_DONE = 29;
  localparam int FUNC_REQ = 30;
  localparam int FUNC_ACK = 31;
  localparam int ENG_DIR_BIT = 0;
  localparam int MEM_DIR_BIT = 1;
  localparam int SEL_SRC = 0;
  localparam int SEL_FAST = 2;
  localparam int SEL_SAT = 3;
  localparam int GEN_ENABLE = 0;
  localparam int GEN_HOLD_DIS = 3;
  localparam int SCLK_CLK_OFF = 1;
  localparam int SCLK_SYNTH_OFF = 2;
  localparam int SCLK_USE_BUS = 4;
  localparam int SCLK_ALL_ON = 5;
  localparam int DLL_SLEEP_LSB = 8;
  localparam int DLL_RESET_LSB = 12;
  localparam int MCLK_DLL_READY = 16;
  localparam int DYN_START_FAST = 1;
  localparam int DYN_MULT_LSB = 2;
  localparam int DYN_STOP_LSB = 11;
  localparam int DYN_STATIC_EN = 20;
  localparam int DYN_LOW_POWER = 22;
  localparam int DYN_STATIC = 23;
  localparam int DYN_FULL_POWER = 24;
  localparam int DYN_GAP_LSB = 25;
  localparam int METER_REF_LSB = 4;
  localparam int METER_CYC_LSB = 8;
  localparam int METER_RESET = 15;
  localparam int METER_COUNT_LSB = 17;
  localparam logic [NUM_REGS-1:0][31:0] CG_RESET = {32'h1002A802, 32'h0000F080,
    32'h0, 32'h0, 32'h0000000C, 32'h0, 32'h00000006, 32'h02000DE5,
    32'h0000000C, 32'h00000001, 32'h00000006, 32'h030008C5};
  localparam logic [NUM_REGS-1:0][31:0] CG_MASK = {32'h3F3FFFFF, 32'h0000FFDF,
    32'h0000003F, 32'h0000000D, 32'h0000000F, 32'h00000002, 32'h0000003F, 32'h47FFFFFF,
    32'h0000000F, 32'h00000001, 32'h0000003F, 32'h43FFFFFF};
  localparam logic [2:0] PLL_WRITE_CYCLES = 3'h4;
  localparam logic [2:0] START_SLOW = 3'h4;
  localparam logic [2:0] START_FAST = 3'h1;
  localparam logic [1:0] SRC_SYNTH = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_BUS = 2'h2;
endpackage

// ==== core/cgpm_gate_if.sv ====
`timescale 1ns/1ns
interface cgpm_gate_if;
  logic enable;
  logic start_fast;
  logic busy;
  logic force_full;
  logic static_en;
  logic [7:0] multiplier;
  logic [7:0] client_delay;
  logic [3:0] stop_delay;
  logic [4:0] gap_tol;
  logic clk_on;
  logic low_power;
  logic static_state;
  modport ctl(input enable, start_fast, busy, force_full, static_en, multiplier,
    client_delay, stop_delay, gap_tol, output clk_on, low_power, static_state);
  modport cfg(output enable, start_fast, busy, force_full, static_en, multiplier,
    client_delay, stop_delay, gap_tol, input clk_on, low_power, static_state);
endinterface

// ==== core/cgpm_gate_ctl.sv ====
`timescale 1ns/1ns
module cgpm_gate_ctl
  import cgpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Gating controls and status
  cgpm_gate_if.ctl u
);
  typedef enum logic [1:0] {G_OFF, G_WAKE, G_ON, G_DRAIN} cgpm_gate_st_t;
  typedef struct packed {
    cgpm_gate_st_t st;
    logic [16:0] cnt;
    logic [4:0] gap;
    logic active;
    logic clk_on;
    logic low_power;
    logic static_state;
  } cgpm_gate_t;
  cgpm_gate_t r_reg, r_next;
  logic [16:0] scaled;
  logic wake;

  // Latency scale and wake condition
  assign scaled = (17'(u.multiplier) + 17'h1) * 17'(u.client_delay);
  assign wake = u.busy || u.force_full;

  // Next state
  always_comb begin
    r_next = r_reg;
    if (u.busy) begin
      r_next.gap = u.gap_tol;
      r_next.active = 1'b1;
    end else if (r_reg.gap != 5'h0) begin
      r_next.gap = r_reg.gap - 5'h1;
    end else begin
      r_next.active = 1'b0;
    end
    if (!u.enable) begin
      r_next.st = G_ON;
    end else begin
      case (r_reg.st)
        G_OFF: if (wake) begin
          r_next.st = G_WAKE;
          r_next.cnt = scaled + 17'(u.start_fast ? START_FAST : START_SLOW) - 17'h1;
        end
        G_WAKE: if (r_reg.cnt == 17'h0) begin
          r_next.st = G_ON;
        end else begin
          r_next.cnt = r_reg.cnt - 17'h1;
        end
        G_ON: if (!r_reg.active && !wake) begin
          r_next.st = G_DRAIN;
          r_next.cnt = scaled + 17'(u.stop_delay);
        end
        G_DRAIN: if (wake) begin
          r_next.st = G_ON;
        end else if (r_reg.cnt == 17'h0) begin
          r_next.st = G_OFF;
        end else begin
          r_next.cnt = r_reg.cnt - 17'h1;
        end
        default: r_next.st = G_ON;
      endcase
    end
    r_next.clk_on = (r_next.st == G_ON) || (r_next.st == G_DRAIN);
    r_next.low_power = (r_next.st == G_OFF) && !u.force_full;
    r_next.static_state = r_next.low_power && u.static_en;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '{st: G_ON, clk_on: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign u.clk_on = r_reg.clk_on;
  assign u.low_power = r_reg.low_power;
  assign u.static_state = r_reg.static_state;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_go_fast;
    r_reg.st == G_OFF && u.enable && u.busy && u.start_fast && u.client_delay == 8'h0;
  endsequence
  sequence s_go_slow;
    r_reg.st == G_OFF && u.enable && u.busy && !u.start_fast && u.client_delay == 8'h0;
  endsequence
  property p_start_fast;
    s_go_fast |=> !u.clk_on ##1 u.clk_on;
  endproperty
  a_start_fast: assert property (p_start_fast) else $error("fast start latency wrong");
  property p_start_slow;
    s_go_slow |=> !u.clk_on [*4] ##1 u.clk_on;
  endproperty
  a_start_slow: assert property (p_start_slow) else $error("slow start latency wrong");
  property p_disabled_on;
    !u.enable |=> u.clk_on && !u.low_power;
  endproperty
  a_disabled_on: assert property (p_disabled_on) else $error("clock gated while off");
  property p_drain_count;
    (r_reg.st == G_DRAIN && u.enable && !wake && r_reg.cnt != 17'h0)
      |=> r_reg.cnt == $past(r_reg.cnt) - 17'h1 && u.clk_on;
  endproperty
  a_drain_count: assert property (p_drain_count) else $error("stop delay miscounted");
  property p_gap_hold;
    (u.busy && u.gap_tol != 5'h0) |=> r_reg.active;
  endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("busy gap not tolerated");
endmodule

// ==== core/cgpm_freq_meter.sv ====
`timescale 1ns/1ns
module cgpm_freq_meter
  import cgpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Candidate clocks from pins
  input wire logic [15:0] clocks,
  // Configuration
  input wire logic [3:0] src_sel,
  input wire logic [3:0] ref_sel,
  input wire logic [6:0] ref_cycles,
  input wire logic counter_reset,
  // Result
  output logic [14:0] count
);
  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [6:0] ref_cnt;
    logic done;
    logic [14:0] count;
  } cgpm_meter_t;
  cgpm_meter_t r_reg, r_next;
  logic [15:0] edges;

  // Rising edges of synchronised clocks
  assign edges = r_reg.s2 & ~r_reg.s3;

  // Count source edges over the reference window
  always_comb begin
    r_next = r_reg;
    r_next.s1 = clocks;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    if (counter_reset) begin
      r_next.ref_cnt = 7'h0;
      r_next.count = 15'h0;
      r_next.done = 1'b0;
    end else if (!r_reg.done) begin
      if (edges[ref_sel]) begin
        if (r_reg.ref_cnt == ref_cycles) r_next.done = 1'b1;
        else r_next.ref_cnt = r_reg.ref_cnt + 7'h1;
      end
      if (edges[src_sel] && r_reg.count != 15'h7FFF) r_next.count = r_reg.count + 15'h1;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) r_reg <= '0;
    else r_reg <= r_next;
  end

  assign count = r_reg.count;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_clear;
    counter_reset |=> count == 15'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("meter not cleared");
  property p_frozen;
    (r_reg.done && !counter_reset) |=> $stable(count);
  endproperty
  a_frozen: assert property (p_frozen) else $error("meter counts after window");
endmodule

// ==== core/cgpm_top.sv ====
`timescale 1ns/1ns
module cgpm_top
  import cgpm_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Host index and data port
  input wire logic [3:0] HOST_ADDR,
  input wire logic HOST_WE,
  input wire logic HOST_RE,
  input wire logic [31:0] HOST_WDATA,
  output logic [31:0] HOST_RDATA,
  output logic HOST_RVALID,
  // Asynchronous status pins
  input wire logic SUSPEND_REQ,
  input wire logic SYNTH_LOCK,
  input wire logic DLL_READY,
  input wire logic [15:0] METER_CLOCKS,
  // Engine activity
  input wire logic ENGINE_BUSY,
  input wire logic [7:0] CLIENT_DELAY,
  // Engine clock synthesiser
  output logic ENG_SYNTH_RESET,
  output logic ENG_SYNTH_POWER_DOWN,
  output logic [2:0] ENG_SYNTH_REF_DIV,
  output logic [7:0] ENG_SYNTH_FB_DIV,
  output logic ENG_SYNTH_PULSE,
  output logic [5:0] ENG_BYPASS_SOURCE,
  output logic [2:0] ENG_REF_CTL,
  // Memory clock synthesiser
  output logic MEM_SYNTH_RESET,
  output logic MEM_SYNTH_POWER_DOWN,
  output logic MEM_SYNTH_AS_MEMCLK,
  output logic [5:0] MEM_BYPASS_SOURCE,
  output logic [2:0] MEM_REF_CTL,
  // Read clock DLLs
  output logic [3:0] READ_DLL_SLEEP,
  output logic [3:0] READ_DLL_RESET,
  // Engine clock and power state
  output logic ENGINE_CLK_EN,
  output logic [1:0] ENGINE_CLK_SOURCE,
  output logic ALL_BRANCHES_ON,
  output logic SUSPEND_ACTIVE,
  output logic LOWER_POWER,
  output logic [1:0] PIXEL_DIVIDER_SET
);
  typedef struct packed {
    logic [9:0] index;
    logic [NUM_REGS-1:0][31:0] regs;
    logic [15:0] meter_cfg;
    logic [1:0] done;
    logic [1:0] ack;
    logic [1:0][2:0] wcnt;
    logic [1:0] pulse_left;
    logic pulse_phase;
    logic eng_pulse;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic suspend;
    logic eng_pd;
    logic clk_en;
    logic [1:0] clk_src;
    logic all_on;
    logic [31:0] rdata;
    logic rvalid;
  } cgpm_top_state_t;

  localparam cgpm_top_state_t TOP_RESET = '{regs: CG_RESET, done: 2'h3, default: '0};

  cgpm_top_state_t r_reg, r_next;
  cgpm_gate_if gif();
  logic [14:0] meter_count;
  logic [6:0] widx;
  logic data_wr;
  logic [1:0] direct_sw;
  logic [1:0] req;
  logic susp_req;
  logic synth_lock;
  logic dll_ready;

  // Synchronised pin levels
  assign susp_req = r_reg.sync2[0];
  assign synth_lock = r_reg.sync2[1];
  assign dll_ready = r_reg.sync2[2];

  // Indexed write decode
  assign widx = r_reg.index[6:0];
  assign data_wr = HOST_WE && HOST_ADDR == ADDR_DATA && r_reg.index[IDX_WE];
  assign direct_sw = {r_reg.regs[IDX_MEM_MODE][MEM_DIR_BIT],
    r_reg.regs[IDX_ENG_MODE][ENG_DIR_BIT]};
  assign req = {r_reg.regs[IDX_MEM_FUNC][FUNC_REQ], r_reg.regs[IDX_ENG_FUNC][FUNC_REQ]};

  // Readback of one indexed register with its live status bits
  function automatic logic [31:0] read_reg(input logic [6:0] idx, input cgpm_top_state_t s,
    input logic [14:0] cnt, input logic lp, input logic ss);
    logic [31:0] v;
    v = 32'h0;
    if (idx < 7'(NUM_REGS)) v = s.regs[idx[3:0]];
    case (idx)
      IDX_ENG_FUNC: begin
        v[FUNC_DONE] = s.done[0];
        v[FUNC_ACK] = s.ack[0];
      end
      IDX_MEM_FUNC: begin
        v[FUNC_DONE] = s.done[1];
        v[FUNC_ACK] = s.ack[1];
      end
      IDX_MCLK: v[MCLK_DLL_READY] = s.sync2[2];
      IDX_DYN: begin
        v[DYN_LOW_POWER] = lp;
        v[DYN_STATIC] = ss;
      end
      IDX_METER: v = {cnt, 1'b0, s.meter_cfg};
      default: v = v;
    endcase
    return v;
  endfunction

  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.sync1 = {DLL_READY, SYNTH_LOCK, SUSPEND_REQ};
    r_next.sync2 = r_reg.sync1;

    // Write completion and mux acknowledge per synthesiser
    for (int i = 0; i < 2; i++) begin
      if (!r_reg.done[i]) begin
        if (r_reg.wcnt[i] == 3'h0) begin
          r_next.done[i] = 1'b1;
          if (direct_sw[i]) r_next.ack[i] = req[i];
        end else begin
          r_next.wcnt[i] = r_reg.wcnt[i] - 3'h1;
        end
      end
    end

    // Pulse train, one cycle high then one low per pulse
    r_next.eng_pulse = 1'b0;
    if (r_reg.pulse_left != 2'h0) begin
      r_next.eng_pulse = !r_reg.pulse_phase;
      r_next.pulse_phase = !r_reg.pulse_phase;
      if (r_reg.pulse_phase) r_next.pulse_left = r_reg.pulse_left - 2'h1;
    end

    // Host writes
    if (HOST_WE && HOST_ADDR == ADDR_INDEX) r_next.index = HOST_WDATA[9:0];
    if (data_wr) begin
      if (widx < 7'(NUM_REGS)) begin
        r_next.regs[widx[3:0]] = (r_reg.regs[widx[3:0]] & ~CG_MASK[widx[3:0]])
          | (HOST_WDATA & CG_MASK[widx[3:0]]);
      end
      if (widx == IDX_METER) r_next.meter_cfg = HOST_WDATA[15:0];
      if (widx == IDX_ENG_FUNC) begin
        r_next.done[0] = 1'b0;
        r_next.wcnt[0] = PLL_WRITE_CYCLES;
        if (HOST_WDATA[FUNC_PULSE_EN]) begin
          r_next.pulse_left = HOST_WDATA[FUNC_PULSE_LSB +: 2];
          r_next.pulse_phase = 1'b0;
        end
      end
      if (widx == IDX_MEM_FUNC) begin
        r_next.done[1] = 1'b0;
        r_next.wcnt[1] = PLL_WRITE_CYCLES;
      end
    end

    // Suspend entry, held until lock unless disabled
    if (susp_req) begin
      r_next.suspend = 1'b1;
    end else if (synth_lock || r_reg.regs[IDX_GEN][GEN_HOLD_DIS]) begin
      r_next.suspend = 1'b0;
    end

    // Engine clock and synth power outputs
    r_next.eng_pd = r_reg.regs[IDX_ENG_FUNC][FUNC_SLEEP]
      || r_reg.regs[IDX_SCLK][SCLK_SYNTH_OFF];
    r_next.all_on = r_reg.suspend && r_reg.regs[IDX_SCLK][SCLK_ALL_ON];
    r_next.clk_en = !r_reg.regs[IDX_SCLK][SCLK_CLK_OFF]
      && (gif.clk_on || r_next.all_on);
    if (!r_reg.suspend) r_next.clk_src = SRC_SYNTH;
    else if (r_reg.regs[IDX_SCLK][SCLK_USE_BUS]) r_next.clk_src = SRC_BUS;
    else r_next.clk_src = SRC_SLOW;

    // Host reads
    r_next.rvalid = HOST_RE;
    r_next.rdata = 32'h0;
    if (HOST_RE && HOST_ADDR == ADDR_INDEX) r_next.rdata = {22'h0, r_reg.index};
    if (HOST_RE && HOST_ADDR == ADDR_DATA) begin
      r_next.rdata = read_reg(widx, r_reg, meter_count, gif.low_power, gif.static_state);
    end
  end

  // State register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      r_reg <= TOP_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Gating controller configuration
  assign gif.enable = r_reg.regs[IDX_GEN][GEN_ENABLE];
  assign gif.start_fast = r_reg.regs[IDX_DYN][DYN_START_FAST];
  assign gif.busy = ENGINE_BUSY;
  assign gif.force_full = r_reg.regs[IDX_DYN][DYN_FULL_POWER];
  assign gif.static_en = r_reg.regs[IDX_DYN][DYN_STATIC_EN];
  assign gif.multiplier = r_reg.regs[IDX_DYN][DYN_MULT_LSB +: 8];
  assign gif.client_delay = CLIENT_DELAY;
  assign gif.stop_delay = r_reg.regs[IDX_DYN][DYN_STOP_LSB +: 4];
  assign gif.gap_tol = r_reg.regs[IDX_DYN][DYN_GAP_LSB +: 5];

  cgpm_gate_ctl u_gate (
    .clk(CLK_SYS),
    .rst(RST),
    .u(gif.ctl)
  );

  cgpm_freq_meter u_meter (
    .clk(CLK_SYS),
    .rst(RST),
    .clocks(METER_CLOCKS),
    .src_sel(r_reg.meter_cfg[3:0]),
    .ref_sel(r_reg.meter_cfg[METER_REF_LSB +: 4]),
    .ref_cycles(r_reg.meter_cfg[METER_CYC_LSB +: 7]),
    .counter_reset(r_reg.meter_cfg[METER_RESET]),
    .count(meter_count)
  );

  // Host outputs
  assign HOST_RDATA = r_reg.rdata;
  assign HOST_RVALID = r_reg.rvalid;

  // Engine synthesiser outputs
  assign ENG_SYNTH_RESET = r_reg.regs[IDX_ENG_FUNC][FUNC_RESET];
  assign ENG_SYNTH_POWER_DOWN = r_reg.eng_pd;
  assign ENG_SYNTH_REF_DIV = r_reg.regs[IDX_ENG_FUNC][FUNC_REF_LSB +: 3];
  assign ENG_SYNTH_FB_DIV = r_reg.regs[IDX_ENG_FUNC][FUNC_FB_LSB +: 8];
  assign ENG_SYNTH_PULSE = r_reg.eng_pulse;
  assign ENG_BYPASS_SOURCE = r_reg.regs[IDX_ENG_BYP][5:0];
  assign ENG_REF_CTL = {r_reg.regs[IDX_ENG_SEL][SEL_SAT], r_reg.regs[IDX_ENG_SEL][SEL_FAST],
    r_reg.regs[IDX_ENG_SEL][SEL_SRC]};

  // Memory synthesiser outputs
  assign MEM_SYNTH_RESET = r_reg.regs[IDX_MEM_FUNC][FUNC_RESET];
  assign MEM_SYNTH_POWER_DOWN = r_reg.regs[IDX_MEM_FUNC][FUNC_SLEEP];
  assign MEM_SYNTH_AS_MEMCLK = r_reg.regs[IDX_MEM_FUNC][MEM_AS_MCLK];
  assign MEM_BYPASS_SOURCE = r_reg.regs[IDX_MEM_BYP][5:0];
  assign MEM_REF_CTL = {r_reg.regs[IDX_MEM_SEL][SEL_SAT], r_reg.regs[IDX_MEM_SEL][SEL_FAST],
    r_reg.regs[IDX_MEM_SEL][SEL_SRC]};

  // DLL and power state outputs
  assign READ_DLL_SLEEP = r_reg.regs[IDX_MCLK][DLL_SLEEP_LSB +: 4];
  assign READ_DLL_RESET = r_reg.regs[IDX_MCLK][DLL_RESET_LSB +: 4];
  assign ENGINE_CLK_EN = r_reg.clk_en;
  assign ENGINE_CLK_SOURCE = r_reg.clk_src;
  assign ALL_BRANCHES_ON = r_reg.all_on;
  assign SUSPEND_ACTIVE = r_reg.suspend;
  assign LOWER_POWER = gif.low_power;
  assign PIXEL_DIVIDER_SET = r_reg.index[PIXEL_LSB +: 2];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence s_eng_write;
    data_wr && widx == IDX_ENG_FUNC;
  endsequence
  property p_write_done;
    s_eng_write ##1 !data_wr [*5] |-> !r_reg.done[0] ##1 r_reg.done[0];
  endproperty
  a_write_done: assert property (p_write_done) else $error("write done timing wrong");
  property p_write_locked;
    (HOST_WE && HOST_ADDR == ADDR_DATA && !r_reg.index[IDX_WE]) |=> $stable(r_reg.regs);
  endproperty
  a_write_locked: assert property (p_write_locked) else $error("write taken while locked");
  property p_index_write;
    (data_wr && widx == IDX_ENG_BYP) |=> ENG_BYPASS_SOURCE == $past(HOST_WDATA[5:0]);
  endproperty
  a_index_write: assert property (p_index_write) else $error("indexed write missed");
  property p_index_read;
    (HOST_RE && HOST_ADDR == ADDR_INDEX)
      |=> HOST_RVALID && HOST_RDATA == {22'h0, $past(r_reg.index)};
  endproperty
  a_index_read: assert property (p_index_read) else $error("index readback wrong");
  property p_clock_off;
    r_reg.regs[IDX_SCLK][SCLK_CLK_OFF] |=> !ENGINE_CLK_EN;
  endproperty
  a_clock_off: assert property (p_clock_off) else $error("engine clock not stopped");
  property p_synth_off;
    r_reg.regs[IDX_SCLK][SCLK_SYNTH_OFF] |=> ENG_SYNTH_POWER_DOWN;
  endproperty
  a_synth_off: assert property (p_synth_off) else $error("synth not powered down");
  property p_hold_suspend;
    (SUSPEND_ACTIVE && !susp_req && !synth_lock && !r_reg.regs[IDX_GEN][GEN_HOLD_DIS])
      |=> SUSPEND_ACTIVE;
  endproperty
  a_hold_suspend: assert property (p_hold_suspend) else $error("suspend left early");
  property p_bus_clock;
    (SUSPEND_ACTIVE && r_reg.regs[IDX_SCLK][SCLK_USE_BUS]) |=> ENGINE_CLK_SOURCE == SRC_BUS;
  endproperty
  a_bus_clock: assert property (p_bus_clock) else $error("suspend clock source wrong");
  property p_pulses;
    (data_wr && widx == IDX_ENG_FUNC && HOST_WDATA[FUNC_PULSE_EN]
      && HOST_WDATA[FUNC_PULSE_LSB +: 2] == 2'h1 && r_reg.pulse_left == 2'h0)
      ##1 !data_wr |-> ##1 ENG_SYNTH_PULSE ##1 !ENG_SYNTH_PULSE;
  endproperty
  a_pulses: assert property (p_pulses) else $error("pulse train wrong");
endmodule

// ==== dv/clock_gen_power_control_tb_top.sv ====
`timescale 1ns/1ns
module clock_gen_power_control_tb_top;
  import cgpm_pkg::*;
  logic clk = 0, rst = 1, we = 0, re = 0, sreq = 0, lock = 0, busy = 0;
  logic [3:0] addr = 4'h0;
  logic [9:0] idx = 10'h000;
  logic [7:0] cdel = 8'h01, fbd;
  logic [31:0] wd = 32'h0, st = 32'hCFFE, rdat, d;
  logic [31:0] mdl [0:127];
  logic vld, srst, pdn, pul, memclk, clken, susp, lowp, allon, mck = 0;
  logic [1:0] csrc;
  logic [2:0] rdiv, rctl;
  logic [5:0] byp;
  logic [3:0] dllr;
  logic [1:0] pix;
  int miscompares = 0, num_checks = 0, n, npul = 0;
  // Clock and pulse counter
  always #20 clk = ~clk;
  always @(posedge clk) if (pul === 1'b1) npul++;
  // Meter test clock, toggled off the sampling edge
  always @(negedge clk) mck <= ~mck;
  cgpm_top DUT (.CLK_SYS(clk), .RST(rst), .HOST_ADDR(addr), .HOST_WE(we), .HOST_RE(re),
    .HOST_WDATA(wd), .HOST_RDATA(rdat), .HOST_RVALID(vld), .SUSPEND_REQ(sreq),
    .SYNTH_LOCK(lock), .DLL_READY(lock), .METER_CLOCKS({15'h0000, mck}), .ENGINE_BUSY(busy),
    .CLIENT_DELAY(cdel), .ENG_SYNTH_RESET(srst), .ENG_SYNTH_POWER_DOWN(pdn),
    .ENG_SYNTH_REF_DIV(rdiv), .ENG_SYNTH_FB_DIV(fbd), .ENG_SYNTH_PULSE(pul),
    .ENG_BYPASS_SOURCE(byp), .ENG_REF_CTL(rctl), .MEM_SYNTH_RESET(),
    .MEM_SYNTH_POWER_DOWN(), .MEM_SYNTH_AS_MEMCLK(memclk), .MEM_BYPASS_SOURCE(),
    .MEM_REF_CTL(), .READ_DLL_SLEEP(), .READ_DLL_RESET(dllr), .ENGINE_CLK_EN(clken),
    .ENGINE_CLK_SOURCE(csrc), .ALL_BRANCHES_ON(allon), .SUSPEND_ACTIVE(susp),
    .LOWER_POWER(lowp),
    .PIXEL_DIVIDER_SET(pix));
  // Xorshift source
  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  // Compare and count
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // Host write, model follows the index write enable
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(negedge clk);
    we = 1;
    addr = a;
    wd = v;
    if (a == ADDR_INDEX) idx = v[9:0];
    else if (idx[IDX_WE]) mdl[idx[6:0]] = v;
    @(negedge clk);
    we = 0;
  endtask
  // Host read, data one cycle after the strobe
  task automatic rd(logic [3:0] a, output logic [31:0] v);
    @(negedge clk);
    re = 1;
    addr = a;
    @(negedge clk);
    re = 0;
    chk("rvalid", 1, vld);
    v = rdat;
  endtask
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    mdl[1] = 32'h6;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 0;
    chk("ref_div", 1, rdiv);
    chk("fb_div", 8'h46, fbd);
    chk("synth_rst", 1, srst);
    chk("ref_ctl", 3'b110, rctl);
    chk("dll_rst", 4'hF, dllr);
    wr(ADDR_INDEX, IDX_ENG_BYP);
    rd(ADDR_INDEX, d);
    chk("idx_rd", 32'(idx), d);
    rd(ADDR_DATA, d);
    chk("byp_rd", 32'h6, d);
    wr(ADDR_DATA, 32'h20);
    rd(ADDR_DATA, d);
    chk("no_we", 32'h6, d);
    // Each pixel set, random one-hot bypass codes
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_INDEX, {22'h0, i[1:0], 8'h81});
      wr(ADDR_DATA, 32'h1 << (rnd() % 6));
      chk("pix", i, pix);
      chk("byp", mdl[1][5:0], byp);
      rd(ADDR_DATA, d);
      rd(ADDR_DATA, d);
      chk("byp_rd", mdl[1], d);
    end
    // Synth write: pulses, write done, request echo
    npul = 0;
    wr(ADDR_INDEX, 32'h80);
    wr(ADDR_DATA, 32'h4000A8C4);
    rd(ADDR_DATA, d);
    chk("done_early", 0, d[FUNC_DONE]);
    repeat (6) @(negedge clk);
    rd(ADDR_DATA, d);
    chk("done", 1, d[FUNC_DONE]);
    chk("ack", 1, d[FUNC_ACK]);
    chk("pulses", 2, npul);
    chk("synth_run", 0, srst);
    npul = 0;
    wr(ADDR_DATA, 32'h400068C4);
    repeat (8) @(negedge clk);
    chk("pulse_one", 1, npul);
    wr(ADDR_INDEX, 32'h84);
    wr(ADDR_DATA, 32'h040008C5);
    wr(ADDR_INDEX, 32'h89);
    wr(ADDR_DATA, 32'h34);
    @(negedge clk);
    chk("memclk", 1, memclk);
    chk("synth_off", 1, pdn);
    // Suspend held until lock
    sreq = 1;
    repeat (5) @(negedge clk);
    chk("susp_on", 1, susp);
    chk("src_bus", SRC_BUS, csrc);
    chk("all_on", 1, allon);
    sreq = 0;
    repeat (5) @(negedge clk);
    chk("susp_hold", 1, susp);
    lock = 1;
    repeat (5) @(negedge clk);
    chk("susp_off", 0, susp);
    wr(ADDR_INDEX, 32'h0A);
    rd(ADDR_DATA, d);
    chk("dll_rd", 32'h0001F080, d);
    // Gating: fast and slow start, random client delay
    wr(ADDR_INDEX, 32'h88);
    wr(ADDR_DATA, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_INDEX, 32'h8B);
      wr(ADDR_DATA, i[0] ? 32'h10002800 : 32'h10002802);
      cdel = (i < 2) ? 8'h00 : 8'(32'h1 + rnd() % 3);
      busy = 0;
      repeat (40) @(negedge clk);
      chk("low_power", 1, lowp);
      chk("clk_off", 0, clken);
      busy = 1;
      n = 0;
      while (clken !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      chk("start_lat", 32'((i[0] ? 4 : 1) + cdel + 2), 32'(n));
    end
    // Software clock stop overrides the busy engine
    wr(ADDR_INDEX, 32'h89);
    wr(ADDR_DATA, 32'h36);
    @(negedge clk);
    chk("clk_stop", 0, clken);
    // Meter: source and reference on one clock count N+1 edges
    wr(ADDR_INDEX, 32'hA1);
    wr(ADDR_DATA, 32'h8000);
    wr(ADDR_DATA, 32'h0300);
    repeat (20) @(negedge clk);
    rd(ADDR_DATA, d);
    chk("meter", {15'h0004, 1'b0, 16'h0300}, d);
    report_and_stop();
  end
endmodule
